//--- verilog/rsj_defs.svh
// Constants of the run/stop/jog speed control block.
// Assumes a 40 MHz system clock and a byte-addressed register port.
`ifndef RSJ_DEFS_SVH
`define RSJ_DEFS_SVH

// Clock rate and measurement window.
`define RSJ_CLK_KHZ        40000
`define RSJ_GATE_TIME_US   1000
`define RSJ_GATE_CYCLES    ((`RSJ_GATE_TIME_US * `RSJ_CLK_KHZ) / 1000)

// Cycles after reset until the three-stage filters hold valid pin levels.
`define RSJ_SETTLE_CYCLES  3'h4

// Register byte offsets.
`define RSJ_OFS_SETPOINT   8'h00
`define RSJ_OFS_JOG_SPEED  8'h04
`define RSJ_OFS_RATIO      8'h08
`define RSJ_OFS_ACCEL      8'h0C
`define RSJ_OFS_DECEL      8'h10
`define RSJ_OFS_GAIN       8'h14
`define RSJ_OFS_STATUS     8'h18
`define RSJ_OFS_FEEDBACK   8'h1C
`define RSJ_OFS_DRIVE      8'h20
`define RSJ_OFS_REFSPEED   8'h24

// Register reset values.
`define RSJ_RST_SETPOINT   16'h0000
`define RSJ_RST_JOG_SPEED  16'h0000
`define RSJ_RST_RATIO      16'h0400
`define RSJ_RST_ACCEL      16'h0001
`define RSJ_RST_DECEL      16'h0001
`define RSJ_RST_GAIN       16'h0100

// Fraction bits of the ratio and of the loop gain.
`define RSJ_RATIO_FRAC     10
`define RSJ_GAIN_FRAC      8

// Status register field positions.
`define RSJ_ST_STATE_LSB   0
`define RSJ_ST_CLOSED_POS  4
`define RSJ_ST_FOLLOW_POS  5
`define RSJ_ST_HOLD_POS    6
`define RSJ_ST_RLATCH_POS  7
`define RSJ_ST_FLATCH_POS  8

`endif

//--- verilog/rsj_pkg.sv
// Types of the run/stop/jog speed control block.
// Assumes rsj_defs.svh supplies the numeric constants.
package rsj_pkg;

  // Operating state of the drive.
  typedef enum logic [2:0] {
    RSJ_STOPPED   = 3'b000,
    RSJ_RUNNING   = 3'b001,
    RSJ_RAMP_STOP = 3'b010,
    RSJ_FAST_STOP = 3'b011,
    RSJ_JOGGING   = 3'b100
  } rsj_state_type;

  // Operator contacts, high while the contact is closed, and the two speed sensor levels.
  typedef struct packed {
    logic run;
    logic ramp_stop_ok;
    logic fast_stop_ok;
    logic jog;
    logic closed_loop;
    logic follower;
    logic ramp_hold;
    logic feedback;
    logic ext_ref;
  } rsj_pins_type;

  // Register port request.
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        write;
    logic        read;
  } rsj_bus_type;

endpackage

//--- verilog/rsj_speed_control.sv
// Run/stop/jog command logic and speed regulator of a DC motor drive.
// Assumes raw contact and sensor inputs from outside the clock domain,
// and a register master on the same clock that never needs wait states.
//
// Functional notes
// [RULE1] A short run closure is latched as the running state.
// [RULE2] Ramp-stop opening latches a stop and ramps down at decel rate.
// [RULE3] Fast-stop opening latches and forces the drive to zero at once.
// [RULE4] Running starts only with both stop contacts closed.
// [RULE5] Jog drives jog speed only while the jog contact stays closed.
// [RULE6] Closed loop integrates setpoint minus feedback toward zero error.
// [RULE7] Open loop drives from the setpoint alone, ignoring feedback.
// [RULE8] Follower command is external reference frequency times ratio.
// [RULE9] Speed is the pulse count of the feedback train per window.
// [RULE10] After reset the drive is stopped with output held at zero.
// [RULE11] Fast stop zeroes the output even while the ramp is held.
// [RULE12] Fast stop beats ramp stop; both beat run and jog.
`include "rsj_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module rsj_speed_control
#(
  parameter int unsigned GATE_CYCLES = `RSJ_GATE_CYCLES
)
(
  // Clock and reset.
  input  wire logic            i_clock,
  input  wire logic            i_rst_n,
  // Operator contacts and speed sensors.
  input  wire rsj_pkg::rsj_pins_type i_pins,
  // Register port.
  input  wire rsj_pkg::rsj_bus_type  i_bus,
  output logic [15:0]          o_rdata,
  // Drive output and state.
  output logic [15:0]          o_drive,
  output rsj_pkg::rsj_state_type o_state
);
  import rsj_pkg::*;

  localparam int NPINS = $bits(rsj_pins_type);

  // Register address match.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  logic [NPINS-1:0] sync1;
  logic [NPINS-1:0] sync2;
  logic [NPINS-1:0] sync3;
  logic [NPINS-1:0] filt_bits;
  rsj_pins_type     pins;
  logic             fb_last;
  logic             ref_last;
  logic             run_last;
  logic             run_edge;
  logic             fb_pulse;
  logic             ref_pulse;
  logic [31:0]      gate_cnt;
  logic             gate_tick;
  logic [15:0]      fb_cnt;
  logic [15:0]      ref_cnt;
  logic [15:0]      fb_speed;
  logic [15:0]      ref_speed;
  logic [15:0]      setpoint;
  logic [15:0]      jog_speed;
  logic [15:0]      ratio;
  logic [15:0]      accel;
  logic [15:0]      decel;
  logic [15:0]      gain;
  rsj_state_type    state;
  rsj_state_type    next_state;
  logic             rstop_latch;
  logic             fstop_latch;
  logic [15:0]      target;
  logic [15:0]      ramp_ref;
  logic [15:0]      next_ramp;
  logic [31:0]      follow_prod;
  logic [15:0]      follow_cmd;
  logic [15:0]      scaled_ref;
  logic signed [16:0] err;
  logic signed [33:0] corr_prod;
  logic signed [25:0] drive_sum;
  logic [15:0]      next_drive;
  logic [2:0]       settle_cnt;
  logic             settled;

  // Three-stage synchronisers; a level is taken when stages two and three agree.
  genvar g;
  generate
    for (g = 0; g < NPINS; g++)
    begin : g_sync
      always_ff @(posedge i_clock or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          sync1[g]     <= 1'b0;
          sync2[g]     <= 1'b0;
          sync3[g]     <= 1'b0;
          filt_bits[g] <= 1'b0;
        end
        else
        begin
          sync1[g] <= i_pins[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
          if (sync2[g] == sync3[g])
            filt_bits[g] <= sync3[g];
        end
      end
    end
  endgenerate

  assign pins = rsj_pins_type'(filt_bits);

  // Filtered pins read as open until the filters have filled after reset.
  // Without this guard the stops would look open and latch a false fast stop.
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      settle_cnt <= 3'h0;
    else if (!settled)
      settle_cnt <= settle_cnt + 3'h1;
  end

  assign settled = (settle_cnt == `RSJ_SETTLE_CYCLES);

  // Edge detection on the filtered run contact and pulse inputs.
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      fb_last  <= 1'b0;
      ref_last <= 1'b0;
      run_last <= 1'b0;
    end
    else
    begin
      fb_last  <= pins.feedback;
      ref_last <= pins.ext_ref;
      run_last <= pins.run;
    end
  end

  assign fb_pulse  = pins.feedback & ~fb_last;
  assign ref_pulse = pins.ext_ref & ~ref_last;
  assign run_edge  = pins.run & ~run_last;

  // Measurement window; also paces the ramp and the regulator.
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      gate_cnt <= 32'h00000000;
    else if (gate_tick)
      gate_cnt <= 32'h00000000;
    else
      gate_cnt <= gate_cnt + 32'h00000001;
  end

  assign gate_tick = (gate_cnt == GATE_CYCLES - 1);

  // [RULE9] Feedback pulse counting.
  // Any sensor type is just rising edges counted per window.
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      fb_cnt   <= 16'h0000;
      fb_speed <= 16'h0000;
    end
    else if (gate_tick)
    begin
      fb_speed <= fb_cnt + {15'h0000, fb_pulse};
      fb_cnt   <= 16'h0000;
    end
    else if (fb_pulse && fb_cnt != 16'hFFFF)
      fb_cnt <= fb_cnt + 16'h0001;
  end

  // External reference frequency counted the same way.
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ref_cnt   <= 16'h0000;
      ref_speed <= 16'h0000;
    end
    else if (gate_tick)
    begin
      ref_speed <= ref_cnt + {15'h0000, ref_pulse};
      ref_cnt   <= 16'h0000;
    end
    else if (ref_pulse && ref_cnt != 16'hFFFF)
      ref_cnt <= ref_cnt + 16'h0001;
  end

  // [RULE8] Follower scaling.
  // Reference speed times ratio, ratio in fixed point, saturated.
  assign follow_prod = ref_speed * ratio;
  assign follow_cmd  = (follow_prod[31:16+`RSJ_RATIO_FRAC] != '0) ? 16'hFFFF :
                       follow_prod[15+`RSJ_RATIO_FRAC:`RSJ_RATIO_FRAC];
  assign scaled_ref  = pins.follower ? follow_cmd : setpoint;

  // Register writes.
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      setpoint  <= `RSJ_RST_SETPOINT;
      jog_speed <= `RSJ_RST_JOG_SPEED;
      ratio     <= `RSJ_RST_RATIO;
      accel     <= `RSJ_RST_ACCEL;
      decel     <= `RSJ_RST_DECEL;
      gain      <= `RSJ_RST_GAIN;
    end
    else if (i_bus.write)
    begin
      if (hit(i_bus.addr, `RSJ_OFS_SETPOINT))
        setpoint <= i_bus.wdata;
      if (hit(i_bus.addr, `RSJ_OFS_JOG_SPEED))
        jog_speed <= i_bus.wdata;
      if (hit(i_bus.addr, `RSJ_OFS_RATIO))
        ratio <= i_bus.wdata;
      if (hit(i_bus.addr, `RSJ_OFS_ACCEL))
        accel <= i_bus.wdata;
      if (hit(i_bus.addr, `RSJ_OFS_DECEL))
        decel <= i_bus.wdata;
      if (hit(i_bus.addr, `RSJ_OFS_GAIN))
        gain <= i_bus.wdata;
    end
  end

  // Register reads, data valid in the cycle after the strobe; unmapped reads zero.
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_rdata <= 16'h0000;
    else if (i_bus.read)
    begin
      case (i_bus.addr)
        `RSJ_OFS_SETPOINT:  o_rdata <= setpoint;
        `RSJ_OFS_JOG_SPEED: o_rdata <= jog_speed;
        `RSJ_OFS_RATIO:     o_rdata <= ratio;
        `RSJ_OFS_ACCEL:     o_rdata <= accel;
        `RSJ_OFS_DECEL:     o_rdata <= decel;
        `RSJ_OFS_GAIN:      o_rdata <= gain;
        `RSJ_OFS_STATUS:    o_rdata <= {7'h00, fstop_latch, rstop_latch,
                                        pins.ramp_hold, pins.follower,
                                        pins.closed_loop, 1'b0, state};
        `RSJ_OFS_FEEDBACK:  o_rdata <= fb_speed;
        `RSJ_OFS_DRIVE:     o_rdata <= o_drive;
        `RSJ_OFS_REFSPEED:  o_rdata <= ref_speed;
        default:            o_rdata <= 16'h0000;
      endcase
    end
    else
      o_rdata <= 16'h0000;
  end

  // Next operating state from the contacts.
  always_comb
  begin
    next_state = state;
    // [RULE12] Stop priority order.
    // [RULE10] Stopped until pins are valid.
    if (!settled)
      next_state = RSJ_STOPPED;
    // [RULE3] Fast stop latch.
    else if (!pins.fast_stop_ok)
      next_state = RSJ_FAST_STOP;
    // [RULE2] Ramp stop latch.
    else if (!pins.ramp_stop_ok)
    begin
      if (state != RSJ_FAST_STOP && state != RSJ_STOPPED)
        next_state = RSJ_RAMP_STOP;
    end
    else
    begin
      case (state)
        RSJ_STOPPED:
        begin
          // [RULE4] Both stops closed.
          // [RULE1] Run edge latched.
          if (run_edge)
            next_state = RSJ_RUNNING;
          else if (pins.jog)
            next_state = RSJ_JOGGING;
        end
        RSJ_RUNNING:   next_state = RSJ_RUNNING;
        RSJ_RAMP_STOP:
        begin
          if (run_edge)
            next_state = RSJ_RUNNING;
          else if (ramp_ref == 16'h0000)
            next_state = RSJ_STOPPED;
        end
        RSJ_FAST_STOP:
        begin
          if (run_edge)
            next_state = RSJ_RUNNING;
          else
            next_state = RSJ_STOPPED;
        end
        RSJ_JOGGING:
        begin
          // [RULE5] Jog only while held.
          if (run_edge)
            next_state = RSJ_RUNNING;
          else if (!pins.jog)
            next_state = RSJ_STOPPED;
        end
        default:       next_state = RSJ_STOPPED;
      endcase
    end
  end

  // [RULE10] Stopped after reset.
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      state <= RSJ_STOPPED;
    else
      state <= next_state;
  end

  // Stop latches for status; a new run clears both.
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rstop_latch <= 1'b0;
      fstop_latch <= 1'b0;
    end
    else
    begin
      if (settled && !pins.fast_stop_ok)
        fstop_latch <= 1'b1;
      else if (next_state == RSJ_RUNNING || next_state == RSJ_JOGGING)
        fstop_latch <= 1'b0;
      if (settled && !pins.ramp_stop_ok)
        rstop_latch <= 1'b1;
      else if (next_state == RSJ_RUNNING || next_state == RSJ_JOGGING)
        rstop_latch <= 1'b0;
    end
  end

  // Ramp target by state.
  always_comb
  begin
    case (state)
      RSJ_RUNNING: target = scaled_ref;
      RSJ_JOGGING: target = jog_speed;
      default:     target = 16'h0000;
    endcase
  end

  // Ramped reference moves one step per window unless held.
  always_comb
  begin
    next_ramp = ramp_ref;
    if (target > ramp_ref)
      next_ramp = (target - ramp_ref > accel) ? ramp_ref + accel : target;
    else if (target < ramp_ref)
      next_ramp = (ramp_ref - target > decel) ? ramp_ref - decel : target;
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ramp_ref <= 16'h0000;
    // [RULE11] Fast stop overrides hold.
    else if (next_state == RSJ_FAST_STOP || next_state == RSJ_STOPPED)
      ramp_ref <= 16'h0000;
    else if (gate_tick && !pins.ramp_hold)
      ramp_ref <= next_ramp;
  end

  // [RULE6] Integrating regulator on the error.
  assign err       = $signed({1'b0, ramp_ref}) - $signed({1'b0, fb_speed});
  assign corr_prod = err * $signed({1'b0, gain});
  assign drive_sum = $signed({10'h000, o_drive}) +
                     $signed(corr_prod[25+`RSJ_GAIN_FRAC:`RSJ_GAIN_FRAC]);

  always_comb
  begin
    if (pins.closed_loop)
    begin
      if (drive_sum < 0)
        next_drive = 16'h0000;
      else if (drive_sum > 26'sh000FFFF)
        next_drive = 16'hFFFF;
      else
        next_drive = drive_sum[15:0];
    end
    else
      // [RULE7] Open loop from setpoint.
      next_drive = ramp_ref;
  end

  // Drive output register.
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_drive <= 16'h0000;
    // [RULE3] Zero at once on fast stop or when stopped.
    else if (next_state == RSJ_FAST_STOP || next_state == RSJ_STOPPED)
      o_drive <= 16'h0000;
    else if (!pins.closed_loop)
      o_drive <= next_drive;
    else if (gate_tick)
      o_drive <= next_drive;
  end

  assign o_state = state;

endmodule

`default_nettype wire

//--- tb/rsj_far_side.sv
// Far-side model: operator contacts and the two speed sensors.
// Assumes the bench sets the contact levels and the sensor half periods.
`timescale 1ns/1ps
`default_nettype none

module rsj_far_side
(
  // Clock and settings.
  input  wire logic                  i_clock,
  input  wire rsj_pkg::rsj_pins_type i_contacts,
  input  wire logic [7:0]            i_fb_half,
  input  wire logic [7:0]            i_ref_half,
  // Levels seen by the drive.
  output rsj_pkg::rsj_pins_type      o_pins
);
  import rsj_pkg::*;
  logic [7:0] half [2];
  logic [7:0] cnt  [2] = '{8'h00, 8'h00};
  logic       lvl  [2] = '{1'b0, 1'b0};
  assign half[0] = i_fb_half;
  assign half[1] = i_ref_half;
  // Each sensor toggles once a half period; a zero half period parks it low.
  always_ff @(posedge i_clock)
  begin
    for (int k = 0; k < 2; k++)
    begin
      cnt[k] <= (cnt[k] + 8'h01 >= half[k]) ? 8'h00 : cnt[k] + 8'h01;
      lvl[k] <= (half[k] == 8'h00) ? 1'b0 : lvl[k] ^ (cnt[k] + 8'h01 >= half[k]);
    end
  end
  // Stop contacts passed through as set.
  // Contacts pass through; the bench keeps an unused stop closed.
  assign o_pins = {i_contacts[8:2], lvl[0], lvl[1]};
endmodule
`default_nettype wire

//--- tb/rsj_speed_control_assertions.sv
// Port checker of the run/stop/jog speed control block.
// Assumes it is bound to every instance of rsj_speed_control.
`timescale 1ns/1ps
`default_nettype none

module rsj_speed_control_assertions
#(
  parameter int unsigned GATE_CYCLES = 40000
)
(
  // Inputs of the block.
  input  wire logic                   i_clock,
  input  wire logic                   i_rst_n,
  input  wire rsj_pkg::rsj_pins_type  i_pins,
  input  wire rsj_pkg::rsj_bus_type   i_bus,
  // Outputs of the block.
  input  wire logic [15:0]            o_rdata,
  input  wire logic [15:0]            o_drive,
  input  wire rsj_pkg::rsj_state_type o_state
);
  import rsj_pkg::*;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  // Stops held closed keep the running state latched.
  a_run_latched: assert property ((o_state == RSJ_RUNNING && i_pins.ramp_stop_ok
    && i_pins.fast_stop_ok)[*8] |=> o_state == RSJ_RUNNING) else $error("run dropped");
  // A latched ramp stop ends at zero speed, in a fast stop, or by a fresh run closure.
  a_ramp_exit: assert property ($changed(o_state) && $past(o_state) == RSJ_RAMP_STOP
    |-> o_state inside {RSJ_STOPPED, RSJ_FAST_STOP}
        || (o_state == RSJ_RUNNING && $past(i_pins.run, 4))) else $error("ramp stop left early");
  a_fast_state: assert property ((!i_pins.fast_stop_ok)[*8]
    |-> o_state == RSJ_FAST_STOP) else $error("fast stop not taken");
  a_fast_zero: assert property (o_state == RSJ_FAST_STOP
    |-> o_drive == 16'h0000) else $error("drive alive in fast stop");
  a_stop_blocks: assert property ((!i_pins.ramp_stop_ok)[*8]
    |-> !(o_state inside {RSJ_RUNNING, RSJ_JOGGING})) else $error("runs with stop open");
  a_jog_ends: assert property ((!i_pins.jog)[*8]
    |-> o_state != RSJ_JOGGING) else $error("jog without contact");
  a_reset_idle: assert property ($rose(i_rst_n)
    |-> o_drive == 16'h0000 && o_state == RSJ_STOPPED) else $error("not idle at reset");
  a_stopped_zero: assert property ((o_state == RSJ_STOPPED)[*3]
    |-> o_drive == 16'h0000) else $error("drive alive when stopped");
  a_rdata_idle: assert property (!$past(i_bus.read)
    |-> o_rdata == 16'h0000) else $error("read data without read");
  // Main scenarios reached.
  c_running: cover property (o_state == RSJ_RUNNING && o_drive != 16'h0000);
  c_jogging: cover property (o_state == RSJ_JOGGING && o_drive != 16'h0000);
  c_fast: cover property (o_state == RSJ_FAST_STOP && i_pins.ramp_hold);
endmodule

bind rsj_speed_control rsj_speed_control_assertions #(.GATE_CYCLES(GATE_CYCLES)) u_chk
(
  .i_clock (i_clock),
  .i_rst_n (i_rst_n),
  .i_pins  (i_pins),
  .i_bus   (i_bus),
  .o_rdata (o_rdata),
  .o_drive (o_drive),
  .o_state (o_state)
);
`default_nettype wire

//--- tb/rsj_speed_control_bench.sv
// Self-checking bench of the run/stop/jog speed control block.
// Assumes the far-side model and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none

module rsj_speed_control_bench;
  import rsj_pkg::*;
  logic          i_clock;
  logic          i_rst_n;
  rsj_pins_type  con;
  rsj_pins_type  pins;
  rsj_bus_type   bus;
  logic [7:0]    fb_half;
  logic [7:0]    ref_half;
  logic [15:0]   rdata;
  logic [15:0]   drive;
  rsj_state_type state;
  logic [15:0]   d0;
  int            n_mismatch = 0;
  int            total_checks = 0;
  int            cycles = 0;
  // Reset values, status with no latch set, and an unmapped offset.
  logic [7:0]    ofs [7] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h30};
  logic [15:0]   rv  [7] = '{16'h0000, 16'h0400, 16'h0001, 16'h0001, 16'h0100,
                             16'h0000, 16'h0000};
  rsj_far_side far
  (
    .i_clock    (i_clock),
    .i_contacts (con),
    .i_fb_half  (fb_half),
    .i_ref_half (ref_half),
    .o_pins     (pins)
  );
  rsj_speed_control #(.GATE_CYCLES(50)) uut
  (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_pins  (pins),
    .i_bus   (bus),
    .o_rdata (rdata),
    .o_drive (drive),
    .o_state (state)
  );
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic so(input rsj_state_type s, input logic [15:0] d);
    #1;
    chk({13'h0000, state}, {13'h0000, s});
    chk(drive, d);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clock);
    bus <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    @(posedge i_clock);
    bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge i_clock);
    bus <= '{addr: a, wdata: 16'h0000, write: 1'b0, read: 1'b1};
    @(posedge i_clock);
    bus <= '0;
    #1;
    chk(rdata, e);
  endtask
  // A short run closure, released well before the outputs are checked.
  task automatic run_pulse;
    @(posedge i_clock);
    con.run <= 1'b1;
    tick(10);
    con.run <= 1'b0;
    tick(10);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Clock of 25 ns.
  initial
  begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  // Cuts a hung run short.
  always @(posedge i_clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 10000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  // Main sequence.
  initial
  begin
    i_rst_n = 1'b0;
    con = 9'h0C0;
    bus = '0;
    fb_half = 8'h05;
    ref_half = 8'h05;
    tick(3);
    i_rst_n <= 1'b1;
    tick(120);
    so(RSJ_STOPPED, 16'h0000);
    for (int k = 0; k < 7; k++)
    begin
      rd(ofs[k], rv[k]);
    end
    rd(8'h1C, 16'h0005);
    @(posedge i_clock) con.fast_stop_ok <= 1'b0;
    run_pulse();
    so(RSJ_FAST_STOP, 16'h0000);
    @(posedge i_clock) con.fast_stop_ok <= 1'b1;
    tick(10);
    so(RSJ_STOPPED, 16'h0000);
    wr(8'h00, 16'h0010);
    wr(8'h0C, 16'h0010);
    wr(8'h10, 16'h0004);
    run_pulse();
    tick(150);
    so(RSJ_RUNNING, 16'h0010);
    @(posedge i_clock) con.ramp_stop_ok <= 1'b0;
    tick(10);
    con.ramp_stop_ok <= 1'b1;
    tick(4);
    #1 chk({13'h0000, state}, {13'h0000, RSJ_RAMP_STOP});
    tick(300);
    so(RSJ_STOPPED, 16'h0000);
    run_pulse();
    tick(150);
    @(posedge i_clock) con.ramp_hold <= 1'b1;
    con.fast_stop_ok <= 1'b0;
    tick(10);
    so(RSJ_FAST_STOP, 16'h0000);
    @(posedge i_clock) con.fast_stop_ok <= 1'b1;
    con.ramp_hold <= 1'b0;
    tick(10);
    so(RSJ_STOPPED, 16'h0000);
    wr(8'h04, 16'h0020);
    @(posedge i_clock) con.jog <= 1'b1;
    tick(200);
    so(RSJ_JOGGING, 16'h0020);
    @(posedge i_clock) con.jog <= 1'b0;
    tick(10);
    so(RSJ_STOPPED, 16'h0000);
    wr(8'h08, 16'h0800);
    @(posedge i_clock) con.follower <= 1'b1;
    run_pulse();
    tick(150);
    so(RSJ_RUNNING, 16'h000A);
    rd(8'h24, 16'h0005);
    @(posedge i_clock) con.ramp_stop_ok <= 1'b0;
    con.fast_stop_ok <= 1'b0;
    tick(10);
    so(RSJ_FAST_STOP, 16'h0000);
    @(posedge i_clock) con <= 9'h0D0;
    fb_half <= 8'h00;
    wr(8'h00, 16'h0005);
    run_pulse();
    tick(300);
    #1 d0 = drive;
    tick(100);
    #1 chk(drive, d0 + 16'h000A);
    end_sim();
  end
endmodule
`default_nettype wire
